/* bench/pcg_deep_sleep_tb.sv */
// Self-checking testbench for the deep-sleep unit clock gate block
`timescale 1ns/1ps
`default_nettype none
`include "pcg_deep_sleep_map.svh"
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end

module pcg_deep_sleep_tb
  import pcg_pkg::*;
;
  logic clk;
  logic rst_b;
  pcg_axi_req_t axiReq;
  pcg_axi_rsp_t axiRsp;
  pcg_pwr_t pwr;
  pcg_unit_t runGate;
  pcg_unit_t sleepGate;
  pcg_unit_t periphAccess;
  pcg_unit_t unitClkEn;
  logic busFault;
  logic irq;
  int errors;
  int checked;
  logic [31:0] rd;
  logic [1:0] rs;
  int pos[8] = '{`PCG_BIT_ASYNC0, `PCG_BIT_ASYNC1, `PCG_BIT_SYNC0, `PCG_BIT_TWOWIRE0,
                 `PCG_BIT_CNT0, `PCG_BIT_CNT1, `PCG_BIT_CNT2, `PCG_BIT_COMPARATOR0};

  pcg_deep_sleep #(.UNITS(8)) i_dut (.clk(clk), .rst_b(rst_b), .axiReq(axiReq),
    .axiRsp(axiRsp), .pwr(pwr), .runGate(runGate), .sleepGate(sleepGate),
    .periphAccess(periphAccess), .unitClkEn(unitClkEn), .busFault(busFault), .irq(irq));

  // ----------------------------------------------------------------
  // Bus master tasks: sample at falling edge, act at rising edge
  // ----------------------------------------------------------------
  task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
    logic ta, tw, awDone, wDone;
    awDone = 0;
    wDone = 0;
    @(posedge clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= s;
    axiReq.bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(negedge clk);
      ta = axiReq.awvalid && (axiRsp.awready === 1'b1);
      tw = axiReq.wvalid && (axiRsp.wready === 1'b1);
      @(posedge clk);
      if (ta) begin
        axiReq.awvalid <= 1'b0;
        awDone = 1;
      end
      if (tw) begin
        axiReq.wvalid <= 1'b0;
        wDone = 1;
      end
    end
    do @(negedge clk); while (axiRsp.bvalid !== 1'b1);
    r = axiRsp.bresp;
    @(posedge clk);
    axiReq.bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    do @(negedge clk); while (axiRsp.arready !== 1'b1);
    @(posedge clk);
    axiReq.arvalid <= 1'b0;
    do @(negedge clk); while (axiRsp.rvalid !== 1'b1);
    d = axiRsp.rdata;
    r = axiRsp.rresp;
    @(posedge clk);
    axiReq.rready <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset state of gate word and enables
  task automatic t_reset();
    @(negedge clk);
    `CHK(unitClkEn, 8'h00)
    `CHK(irq, 1'b0)
    axiRead(32'(`PCG_OFF_DS_GATE), rd, rs);
    `CHK(rd, 32'h0000_0000)
  endtask

  // Each gate bit alone drives exactly its own unit in deep sleep
  task automatic t_bits();
    pwr <= 3'b101;
    for (int i = 0; i < 8; i++) begin
      axiWrite(32'(`PCG_OFF_DS_GATE), 32'h1 << pos[i], 4'hF, rs);
      axiRead(32'(`PCG_OFF_DS_GATE), rd, rs);
      `CHK(rd, 32'h1 << pos[i])
      repeat (2) @(negedge clk);
      `CHK(unitClkEn, pcg_unit_t'(8'h01 << i))
    end
  endtask

  // Reserved bits read zero; strobed lanes only
  task automatic t_reserved();
    axiWrite(32'(`PCG_OFF_DS_GATE), 32'hFFFF_FFFF, 4'hF, rs);
    `CHK(rs, `PCG_RESP_OKAY)
    axiRead(32'(`PCG_OFF_DS_GATE), rd, rs);
    `CHK(rd, 32'h0107_1013)
    axiWrite(32'(`PCG_OFF_DS_GATE), 32'h0000_0000, 4'h1, rs);
    axiRead(32'(`PCG_OFF_DS_GATE), rd, rs);
    `CHK(rd, 32'h0107_1000)
  endtask

  // Enable source chosen by auto select and power state
  task automatic t_modes();
    logic [2:0] md[6] = '{3'b001, 3'b010, 3'b110, 3'b101, 3'b100, 3'b111};
    pcg_unit_t ex[6] = '{8'hA5, 8'hA5, 8'h3C, 8'hF8, 8'hA5, 8'hF8};
    runGate <= 8'hA5;
    sleepGate <= 8'h3C;
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      pwr <= pcg_pwr_t'(md[k]);
      repeat (3) @(negedge clk);
      `CHK(unitClkEn, ex[k])
    end
    axiRead(32'(`PCG_OFF_EFF_EN), rd, rs);
    `CHK(rd, 32'h0000_00F8)
  endtask

  // Access to one unit for one cycle, then look at the fault outputs
  task automatic poke(input pcg_unit_t u, input logic expF, input logic expI);
    @(posedge clk);
    periphAccess <= u;
    @(posedge clk);
    periphAccess <= 8'h00;
    @(negedge clk);
    `CHK(busFault, expF)
    `CHK(irq, expI)
  endtask

  // Faults on unclocked units, masking, clearing
  task automatic t_faults();
    pwr <= 3'b101;
    axiWrite(32'(`PCG_OFF_DS_GATE), 32'h0000_1000, 4'hF, rs);
    repeat (2) @(negedge clk);
    poke(8'h08, 1'b0, 1'b0);
    poke(8'h04, 1'b1, 1'b0);
    @(negedge clk);
    `CHK(busFault, 1'b0)
    axiRead(32'(`PCG_OFF_FLT_STAT), rd, rs);
    `CHK(rd, 32'h0000_0004)
    axiWrite(32'(`PCG_OFF_FLT_EN), 32'h0000_00FF, 4'hF, rs);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b1)
    axiRead(32'(`PCG_OFF_FLT_EN), rd, rs);
    `CHK(rd, 32'h0000_00FF)
    axiWrite(32'(`PCG_OFF_FLT_CLR), 32'h0000_0004, 4'hF, rs);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
    poke(8'h80, 1'b1, 1'b1);
  endtask

  // Reset in mid-run clears gates, enables, fault status and interrupt
  task automatic t_midreset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    `CHK(unitClkEn, 8'h00)
    `CHK(irq, 1'b0)
    axiRead(32'(`PCG_OFF_DS_GATE), rd, rs);
    `CHK(rd, 32'h0000_0000)
    axiRead(32'(`PCG_OFF_FLT_STAT), rd, rs);
    `CHK(rd, 32'h0000_0000)
  endtask

  // Unmapped address answers with slave error
  task automatic t_unmapped();
    axiWrite(32'h0000_0200, 32'h1234_5678, 4'hF, rs);
    `CHK(rs, 2'h2)
    axiRead(32'h0000_0200, rd, rs);
    `CHK(rs, 2'h2)
    `CHK(rd, 32'h0000_0000)
  endtask

  // ----------------------------------------------------------------
  // Clock, verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cuts a hung handshake short
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  initial begin
    errors = 0;
    checked = 0;
    rst_b = 1'b0;
    axiReq = '0;
    pwr = '0;
    runGate = 8'h00;
    sleepGate = 8'h00;
    periphAccess = 8'h00;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_bits();
    t_reserved();
    t_modes();
    t_faults();
    t_midreset();
    t_unmapped();
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* hdl/pcg_deep_sleep.sv */
// Deep-sleep unit clock gate register with clock enable selection and fault logic
//
// What this block does
// - Each writable bit gates exactly one unit
// - Bit one clocks unit; zero leaves it off
// - Access to unclocked unit returns bus fault
// - Reset clears every gate bit to zero
// - Gate word at 0x124 serves deep sleep
// - Sleep registers apply only with auto gating
// - Bit 24 gates analog comparator zero
// - Bits 18,17,16 gate counters two,one,zero
// - Bit 12 two-wire port, bit 4 sync serial
// - Bits 1,0 gate async serial one,zero
// - Reserved bits read zero, ignore writes
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_deep_sleep_map.svh"

module pcg_deep_sleep
  import pcg_pkg::*;
#(
  parameter int UNITS = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire pcg_axi_req_t axiReq,
  output var pcg_axi_rsp_t axiRsp,
  input wire pcg_pwr_t pwr,
  input wire pcg_unit_t runGate,
  input wire pcg_unit_t sleepGate,
  input wire pcg_unit_t periphAccess,
  output var pcg_unit_t unitClkEn,
  output var logic busFault,
  output var logic irq
);

  // ----------------------------------------------------------------
  // Elaboration checks and constants
  // ----------------------------------------------------------------
  if (UNITS != 8) begin : g_bad_units
    $error("pcg_deep_sleep serves exactly eight gated units");
  end

  // Word position of each unit's gate bit, in unit index order
  localparam int unsigned POS [8] = '{
    `PCG_BIT_ASYNC0, `PCG_BIT_ASYNC1,
    `PCG_BIT_SYNC0, `PCG_BIT_TWOWIRE0,
    `PCG_BIT_CNT0, `PCG_BIT_CNT1, `PCG_BIT_CNT2,
    `PCG_BIT_COMPARATOR0
  };

  // Whole block state
  typedef struct packed {
    pcg_axi_rsp_t rsp;
    pcg_wst_t wst;
    logic [31:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    pcg_unit_t dsGate;
    pcg_unit_t unitClkEn;
    logic busFault;
    pcg_unit_t fltStat;
    pcg_unit_t fltEn;
    logic irq;
  } pcg_state_t;

  // Spread unit bits onto their word positions, all else zero
  function automatic logic [31:0] spread(input pcg_unit_t u);
    spread = 32'h0000_0000;
    for (int i = 0; i < 8; i++) begin
      spread[POS[i]] = u[i];
    end
  endfunction

  // Gather unit bits out of a word
  function automatic pcg_unit_t gather(input logic [31:0] w);
    gather = 8'h00;
    for (int i = 0; i < 8; i++) begin
      gather[i] = w[POS[i]];
    end
  endfunction

  localparam pcg_state_t RST_STATE = '{
    rsp: '{awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: `PCG_RESP_OKAY,
           arready: 1'b1, rvalid: 1'b0, rdata: 32'h0000_0000, rresp: `PCG_RESP_OKAY},
    wst: PCG_W_IDLE,
    awAddr: 32'h0000_0000,
    wData: 32'h0000_0000,
    wStrb: 4'h0,
    dsGate: gather(`PCG_DS_RST),
    unitClkEn: gather(`PCG_DS_RST),
    busFault: 1'b0,
    fltStat: `PCG_FLT_RST,
    fltEn: `PCG_FLT_RST,
    irq: 1'b0
  };

  pcg_state_t s_q;
  pcg_state_t s_d;
  pcg_unit_t dsWrBit;
  pcg_unit_t fltEvt;
  logic wrFire;
  logic [`PCG_DEC_W-1:0] wrOff;
  logic [`PCG_DEC_W-1:0] rdOff;

  // ----------------------------------------------------------------
  // Per-unit write data with byte strobes
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_unit
    // Each unit owns one bit; byte lane of that bit must be strobed
    assign dsWrBit[i] = s_q.wStrb[POS[i] / 8] ? s_q.wData[POS[i]] : s_q.dsGate[i];
  end

  // Write is carried out once address and data are both held
  assign wrFire = (s_q.wst == PCG_W_IDLE) && !s_q.rsp.awready && !s_q.rsp.wready;
  assign wrOff = s_q.awAddr[`PCG_DEC_W-1:0];
  assign rdOff = axiReq.araddr[`PCG_DEC_W-1:0];
  // Access to a unit whose clock is cut
  assign fltEvt = periphAccess & ~s_q.unitClkEn;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    pcg_unit_t clr;
    clr = 8'h00;
    s_d = s_q;

    // Address and data channels taken in either order
    if (axiReq.awvalid && s_q.rsp.awready) begin
      s_d.rsp.awready = 1'b0;
      s_d.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && s_q.rsp.wready) begin
      s_d.rsp.wready = 1'b0;
      s_d.wData = axiReq.wdata;
      s_d.wStrb = axiReq.wstrb;
    end

    // Write decode and response
    case (s_q.wst)
      PCG_W_IDLE: begin
        if (wrFire) begin
          s_d.rsp.bvalid = 1'b1;
          s_d.rsp.bresp = `PCG_RESP_OKAY;
          s_d.wst = PCG_W_RESP;
          case (wrOff)
            `PCG_OFF_DS_GATE: s_d.dsGate = dsWrBit;
            `PCG_OFF_FLT_CLR: begin
              if (s_q.wStrb[0]) begin
                clr = s_q.wData[7:0];
              end
            end
            `PCG_OFF_FLT_EN: begin
              if (s_q.wStrb[0]) begin
                s_d.fltEn = s_q.wData[7:0];
              end
            end
            `PCG_OFF_FLT_STAT, `PCG_OFF_EFF_EN: s_d.rsp.bresp = `PCG_RESP_OKAY;
            default: s_d.rsp.bresp = `PCG_RESP_SLVERR;
          endcase
        end
      end
      PCG_W_RESP: begin
        if (axiReq.bready) begin
          s_d.rsp.bvalid = 1'b0;
          s_d.rsp.awready = 1'b1;
          s_d.rsp.wready = 1'b1;
          s_d.wst = PCG_W_IDLE;
        end
      end
      default: s_d.wst = PCG_W_IDLE;
    endcase

    // Read address taken, data one cycle later
    if (axiReq.arvalid && s_q.rsp.arready) begin
      s_d.rsp.arready = 1'b0;
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rresp = `PCG_RESP_OKAY;
      case (rdOff)
        `PCG_OFF_DS_GATE: s_d.rsp.rdata = spread(s_q.dsGate);
        `PCG_OFF_FLT_STAT: s_d.rsp.rdata = {24'h00_0000, s_q.fltStat};
        `PCG_OFF_FLT_EN: s_d.rsp.rdata = {24'h00_0000, s_q.fltEn};
        `PCG_OFF_EFF_EN: s_d.rsp.rdata = {24'h00_0000, s_q.unitClkEn};
        `PCG_OFF_FLT_CLR: s_d.rsp.rdata = 32'h0000_0000;
        default: begin
          s_d.rsp.rdata = 32'h0000_0000;
          s_d.rsp.rresp = `PCG_RESP_SLVERR;
        end
      endcase
    end else if (s_q.rsp.rvalid && axiReq.rready) begin
      s_d.rsp.rvalid = 1'b0;
      s_d.rsp.arready = 1'b1;
    end

    // Effective enable: run bits unless auto gating picks a low-power set
    if (!pwr.autoClockGatingSelect || !(pwr.sleepNow || pwr.deepSleepNow)) begin
      s_d.unitClkEn = runGate;
    end else if (pwr.deepSleepNow) begin
      s_d.unitClkEn = s_q.dsGate;
    end else begin
      s_d.unitClkEn = sleepGate;
    end

    // Fault pulse and sticky status; a new fault beats a clear
    s_d.busFault = |fltEvt;
    s_d.fltStat = (s_q.fltStat & ~clr) | fltEvt;
    s_d.irq = |(s_d.fltStat & s_d.fltEn);
  end

  // Registered state, synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops
  assign axiRsp = s_q.rsp;
  assign unitClkEn = s_q.unitClkEn;
  assign busFault = s_q.busFault;
  assign irq = s_q.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_ds_write;
    wrFire && (wrOff == `PCG_OFF_DS_GATE);
  endsequence

  sequence s_ar_take;
    axiReq.arvalid && s_q.rsp.arready;
  endsequence

  sequence s_clr_write;
    wrFire && (wrOff == `PCG_OFF_FLT_CLR) && s_q.wStrb[0];
  endsequence

  property p_ds_write;
    s_ds_write |=> (s_q.dsGate == $past(dsWrBit)) ##0 s_q.rsp.bvalid;
  endproperty

  property p_ds_hold;
    !(wrFire && (wrOff == `PCG_OFF_DS_GATE)) |=> (s_q.dsGate == $past(s_q.dsGate));
  endproperty

  property p_run_sel;
    !(pwr.autoClockGatingSelect) |=> (unitClkEn == $past(runGate));
  endproperty

  property p_deep_sel;
    (pwr.autoClockGatingSelect && pwr.deepSleepNow) |=> (unitClkEn == $past(s_q.dsGate));
  endproperty

  property p_sleep_sel;
    (pwr.autoClockGatingSelect && pwr.sleepNow && !pwr.deepSleepNow)
      |=> (unitClkEn == $past(sleepGate));
  endproperty

  property p_fault;
    (|(periphAccess & ~unitClkEn)) |=> busFault ##0 ((s_q.fltStat & $past(fltEvt)) == $past(fltEvt));
  endproperty

  property p_no_fault;
    !(|(periphAccess & ~unitClkEn)) |=> !busFault;
  endproperty

  property p_reset;
    $rose(rst_b) |-> (s_q.dsGate == 8'h00) && (unitClkEn == 8'h00) && !irq;
  endproperty

  property p_resv_zero;
    (s_ar_take ##0 (rdOff == `PCG_OFF_DS_GATE))
      |=> axiRsp.rvalid ##0 ((axiRsp.rdata & ~spread(8'hFF)) == 32'h0000_0000);
  endproperty

  property p_bit_map;
    (s_ar_take ##0 (rdOff == `PCG_OFF_DS_GATE))
      |=> (gather(axiRsp.rdata) == $past(s_q.dsGate))
      ##0 (axiRsp.rdata[`PCG_BIT_COMPARATOR0] == $past(s_q.dsGate[7]));
  endproperty

  property p_irq;
    ##1 (irq == |(s_q.fltStat & s_q.fltEn));
  endproperty

  // Fault status: cleared bits drop unless hit again, others stay set
  property p_flt_clear;
    s_clr_write |=> ((s_q.fltStat & $past(s_q.wData[7:0]) & ~$past(fltEvt)) == 8'h00);
  endproperty

  property p_flt_sticky;
    !(wrFire && (wrOff == `PCG_OFF_FLT_CLR))
      |=> ((s_q.fltStat & $past(s_q.fltStat)) == $past(s_q.fltStat));
  endproperty

  // Decode: gate word answers OKAY, unmapped offsets answer with an error
  property p_gate_ok;
    (s_ar_take ##0 (rdOff == `PCG_OFF_DS_GATE)) |=> (axiRsp.rresp == `PCG_RESP_OKAY);
  endproperty

  property p_rd_err;
    (s_ar_take ##0 !(rdOff inside {`PCG_OFF_DS_GATE, `PCG_OFF_FLT_STAT, `PCG_OFF_FLT_CLR,
      `PCG_OFF_FLT_EN, `PCG_OFF_EFF_EN}))
      |=> (axiRsp.rresp == `PCG_RESP_SLVERR) && (axiRsp.rdata == 32'h0000_0000);
  endproperty

  property p_wr_err;
    (wrFire && !(wrOff inside {`PCG_OFF_DS_GATE, `PCG_OFF_FLT_STAT, `PCG_OFF_FLT_CLR,
      `PCG_OFF_FLT_EN, `PCG_OFF_EFF_EN}))
      |=> s_q.rsp.bvalid && (axiRsp.bresp == `PCG_RESP_SLVERR);
  endproperty

  property p_eff_read;
    (s_ar_take ##0 (rdOff == `PCG_OFF_EFF_EN))
      |=> (axiRsp.rdata == {24'h00_0000, $past(unitClkEn)});
  endproperty

  a_ds_write: assert property (p_ds_write) else $error("gate write not stored");
  a_ds_hold: assert property (p_ds_hold) else $error("gate changed without write");
  a_run_sel: assert property (p_run_sel) else $error("run enables not applied");
  a_deep_sel: assert property (p_deep_sel) else $error("deep enables not applied");
  a_sleep_sel: assert property (p_sleep_sel) else $error("sleep enables not applied");
  a_fault: assert property (p_fault) else $error("missing bus fault");
  a_no_fault: assert property (p_no_fault) else $error("spurious bus fault");
  a_reset: assert property (p_reset) else $error("gates not clear after reset");
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bits read nonzero");
  a_bit_map: assert property (p_bit_map) else $error("unit bits misplaced");
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
  a_flt_clear: assert property (p_flt_clear) else $error("fault status not cleared");
  a_flt_sticky: assert property (p_flt_sticky) else $error("fault status dropped");
  a_gate_ok: assert property (p_gate_ok) else $error("gate word read refused");
  a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
  a_wr_err: assert property (p_wr_err) else $error("unmapped write not refused");
  a_eff_read: assert property (p_eff_read) else $error("effective enables misread");

endmodule

`default_nettype wire

/* hdl/pcg_deep_sleep_map.svh */
// Register offsets, field positions and reset values of the gating block
`ifndef PCG_DEEP_SLEEP_MAP_SVH
`define PCG_DEEP_SLEEP_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets (low address bits decoded)
// ----------------------------------------------------------------
`define PCG_DEC_W 12
`define PCG_OFF_DS_GATE 12'h124
`define PCG_OFF_FLT_STAT 12'h130
`define PCG_OFF_FLT_CLR 12'h134
`define PCG_OFF_FLT_EN 12'h138
`define PCG_OFF_EFF_EN 12'h13C

// ----------------------------------------------------------------
// Unit gate bit positions inside the deep-sleep gate word
// ----------------------------------------------------------------
`define PCG_BIT_ASYNC0 0
`define PCG_BIT_ASYNC1 1
`define PCG_BIT_SYNC0 4
`define PCG_BIT_TWOWIRE0 12
`define PCG_BIT_CNT0 16
`define PCG_BIT_CNT1 17
`define PCG_BIT_CNT2 18
`define PCG_BIT_COMPARATOR0 24

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define PCG_DS_RST 32'h0000_0000
`define PCG_FLT_RST 8'h00
`define PCG_RESP_OKAY 2'h0
`define PCG_RESP_SLVERR 2'h2

`endif

/* hdl/pcg_pkg.sv */
// Types shared by the deep-sleep clock gating block
`default_nettype none

package pcg_pkg;

  // One bit per gated unit, index order: async0, async1, sync0, twowire0, cnt0..2, comparator_zero_gate
  typedef logic [7:0] pcg_unit_t;

  // AXI4-Lite master-to-slave signals
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } pcg_axi_req_t;

  // AXI4-Lite slave-to-master signals
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pcg_axi_rsp_t;

  // Power state seen from the system controller
  typedef struct packed {
    logic autoClockGatingSelect;
    logic sleepNow;
    logic deepSleepNow;
  } pcg_pwr_t;

  // Write channel progress
  typedef enum logic [1:0] {
    PCG_W_IDLE = 2'b01,
    PCG_W_RESP = 2'b10
  } pcg_wst_t;

endpackage

`default_nettype wire
